// *** hdl/cfgopt_pkg.sv ***
// Constants for the configuration option register block.
// Assumes a 32-bit register port with 5-bit word addresses.
package cfgopt_pkg;

  // ----------------------------------------------------------------
  // Register word addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_FRAME_DATA_INPUT = 5'h02;
  localparam logic [4:0] ADDR_COMMAND = 5'h04;
  localparam logic [4:0] ADDR_CONFIG_OPTIONS_FIRST = 5'h09;
  localparam logic [4:0] ADDR_MULTI_FRAME_WRITE = 5'h0A;
  localparam logic [4:0] ADDR_CIPHER_INIT_VECTOR = 5'h0B;
  localparam logic [4:0] ADDR_DEVICE_IDENTIFIER = 5'h0C;
  localparam logic [4:0] ADDR_USER_ACCESS_WORD = 5'h0D;
  localparam logic [4:0] ADDR_CONFIG_OPTIONS_SECOND = 5'h0E;

  // ----------------------------------------------------------------
  // Command codes written to the command register
  // ----------------------------------------------------------------
  localparam logic [4:0] CMD_START = 5'h05;
  localparam logic [4:0] CMD_COMMAND_A = 5'h0D;

  // ----------------------------------------------------------------
  // First options register fields
  // ----------------------------------------------------------------
  localparam int LOCK_LSB = 6;
  localparam int TRISTATE_LSB = 3;
  localparam int WRITE_EN_LSB = 0;
  localparam int DONE_PIPE_BIT = 25;
  localparam logic [31:0] FIRST_RESET = 32'h02003FEC;
  localparam logic [31:0] FIRST_MASK = 32'h020001FF;

  // ----------------------------------------------------------------
  // Second options register fields
  // ----------------------------------------------------------------
  localparam int PIN_PERSISTENCE_REL_BIT = 17;
  localparam int CRC_RESP_LSB = 15;
  localparam int CRC_NO_PIN_BIT = 9;
  localparam int CRC_EN_BIT = 8;
  localparam int FIRST_READ_LSB = 2;
  localparam int PAGE_LSB = 0;
  localparam logic [31:0] SECOND_RESET = 32'h00000000;
  localparam logic [31:0] SECOND_MASK = 32'h0003830F;
  localparam logic [1:0] PAGE_RESERVED = 2'h3;

  // ----------------------------------------------------------------
  // Phase codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_TRACK_DONE = 3'h6;
  localparam logic [2:0] CODE_KEEP = 3'h7;
  localparam logic [2:0] PHASE_LAST = 3'h7;

  // Startup sequencer states
  typedef enum logic [1:0] {CFGOPT_IDLE, CFGOPT_RUN, CFGOPT_END} cfgopt_seq_e;

endpackage : cfgopt_pkg

// *** hdl/cfgopt_rel_if.sv ***
// Interface between the startup sequencer and one release unit.
// Assumes all members live on the one block clock.
`timescale 1ns/1ps
interface cfgopt_rel_if;
  logic [2:0] code;
  logic [2:0] phase;
  logic running;
  logic done;
  logic asserted;

  modport seq (output code, output phase, output running, output done,
               input asserted);
  modport rel (input code, input phase, input running, input done,
               output asserted);
endinterface : cfgopt_rel_if

// *** hdl/cfgopt_release.sv ***
// One global control that the startup sequence releases at a phase.
// Assumes the sequencer drives phase 0 to 7 while running.
`timescale 1ns/1ps
module cfgopt_release (
  input wire logic clock,
  input wire logic resetn,
  cfgopt_rel_if.rel rel
);

  logic asserted_q;

  // Held until the configured phase, the done level, or never
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      asserted_q <= 1'b1;
    end
    else if (rel.running)
    begin
      case (rel.code)
        cfgopt_pkg::CODE_TRACK_DONE: asserted_q <= ~rel.done; // [R02] [R03]
        cfgopt_pkg::CODE_KEEP: asserted_q <= 1'b1; // [R02] [R03]
        default:
        begin
          if (rel.phase == rel.code + 3'h1)
          begin
            asserted_q <= 1'b0; // [R02] [R03] [R16]
          end
        end
      endcase
    end
  end

  assign rel.asserted = asserted_q;

endmodule : cfgopt_release

// *** hdl/cfgopt_top.sv ***
// Configuration option registers and startup release sequencer.
// Assumes the configuration port presents one word per cycle on clock,
// and that the lock and done pins are asynchronous to clock.
//
// Contract
// (R01) Lock field bits 8:6 picks the phase stalled until clock managers lock.
// (R02) Tristate field bits 5:3 picks release phase; 6 follows done, 7 keeps.
// (R03) Write enable field bits 2:0 likewise picks release phase.
// (R04) Frame data is accepted only after a matching identifier write.
// (R05) Reading the identifier register returns the fixed device code.
// (R06) The 32-bit user access word is writable and shown to fabric.
// (R07) Cipher vector register stores the decryption initial vector.
// (R08) Multi-frame write register takes writes only with compression active.
// (R09) Bit 17 set lets command A drop pin persistence; clear keeps it.
// (R10) Bits 16:15 select readback CRC error response.
// (R11) Bit 9 clear lets the init pin report CRC errors; set hides them.
// (R12) Bit 8 enables continuous readback CRC checking.
// (R13) Bits 3:2 set first flash read latency, one to four cycles.
// (R14) Bits 1:0 set flash page size 1, 4 or 8; code 3 reserved.
// (R15) Done pipeline option delays the done level by one clock.
// (R16) Sequencer steps a phase per clock and stalls in the wait phase.
`timescale 1ns/1ps
module cfgopt_top #(
  parameter logic [31:0] DEVICE_ID = 32'h0A5A5001 // Arbitrary value
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [4:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata_q,
  output logic cfg_rvalid_q,
  input wire logic compression_active,
  input wire logic clock_manager_locked,
  input wire logic done_pin,
  input wire logic readback_crc_error,
  output logic [31:0] frame_data_q,
  output logic frame_valid_q,
  output logic id_error_q,
  output logic [31:0] user_access_word_q,
  output logic [31:0] cipher_init_vector_q,
  output logic [31:0] multi_frame_write_q,
  output logic global_tristate_q,
  output logic global_write_enable_q,
  output logic startup_done_q,
  output logic pin_persistence_q,
  output logic [1:0] readback_crc_response_q,
  output logic readback_crc_enable_q,
  output logic init_error_q,
  output logic [2:0] first_read_latency_q,
  output logic [3:0] flash_page_words_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] first_q;
  logic [31:0] second_q;
  logic id_ok_q;
  logic lock_s1_q;
  logic lock_s2_q;
  logic done_s1_q;
  logic done_s2_q;
  logic done_pipe_q;
  logic done_seen;
  logic [2:0] phase_q;
  logic [2:0] lock_code;
  logic stall;
  cfgopt_pkg::cfgopt_seq_e state_q;
  logic wr_cmd;
  logic [31:0] rd_word;

  cfgopt_rel_if tri_if ();
  cfgopt_rel_if gwe_if ();

  // Command register write decode
  assign wr_cmd = cfg_write && (cfg_addr == cfgopt_pkg::ADDR_COMMAND);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops for each asynchronous pin
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
    end
    else
    begin
      lock_s1_q <= clock_manager_locked;
      lock_s2_q <= lock_s1_q;
      done_s1_q <= done_pin;
      done_s2_q <= done_s1_q;
    end
  end

  // Optional extra stage on the done level
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      done_pipe_q <= 1'b0;
    end
    else
    begin
      done_pipe_q <= done_s2_q; // [R15]
    end
  end

  assign done_seen = first_q[cfgopt_pkg::DONE_PIPE_BIT] ? done_pipe_q
                                                        : done_s2_q; // [R15]

  // ----------------------------------------------------------------
  // Option registers
  // ----------------------------------------------------------------
  // First options register, writable bits only
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      first_q <= cfgopt_pkg::FIRST_RESET;
    end
    else if (cfg_write &&
             (cfg_addr == cfgopt_pkg::ADDR_CONFIG_OPTIONS_FIRST))
    begin
      first_q <= (cfg_wdata & cfgopt_pkg::FIRST_MASK) |
                 (cfgopt_pkg::FIRST_RESET & ~cfgopt_pkg::FIRST_MASK);
    end
  end

  // Second options register; a reserved page code keeps the old page
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      second_q <= cfgopt_pkg::SECOND_RESET;
    end
    else if (cfg_write &&
             (cfg_addr == cfgopt_pkg::ADDR_CONFIG_OPTIONS_SECOND))
    begin
      second_q <= cfg_wdata & cfgopt_pkg::SECOND_MASK;
      if (cfg_wdata[cfgopt_pkg::PAGE_LSB +: 2] == cfgopt_pkg::PAGE_RESERVED)
      begin
        second_q[cfgopt_pkg::PAGE_LSB +: 2] <=
          second_q[cfgopt_pkg::PAGE_LSB +: 2]; // [R14]
      end
    end
  end

  // User access, cipher vector and multi-frame words
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      user_access_word_q <= 32'h00000000;
      cipher_init_vector_q <= 32'h00000000;
      multi_frame_write_q <= 32'h00000000;
    end
    else if (cfg_write)
    begin
      if (cfg_addr == cfgopt_pkg::ADDR_USER_ACCESS_WORD)
      begin
        user_access_word_q <= cfg_wdata; // [R06]
      end
      if (cfg_addr == cfgopt_pkg::ADDR_CIPHER_INIT_VECTOR)
      begin
        cipher_init_vector_q <= cfg_wdata; // [R07]
      end
      if ((cfg_addr == cfgopt_pkg::ADDR_MULTI_FRAME_WRITE) &&
          compression_active)
      begin
        multi_frame_write_q <= cfg_wdata; // [R08]
      end
    end
  end

  // ----------------------------------------------------------------
  // Identifier check and frame data
  // ----------------------------------------------------------------
  // Match flag follows the latest identifier write
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      id_ok_q <= 1'b0;
      id_error_q <= 1'b0;
    end
    else if (cfg_write && (cfg_addr == cfgopt_pkg::ADDR_DEVICE_IDENTIFIER))
    begin
      id_ok_q <= (cfg_wdata == DEVICE_ID); // [R04]
      id_error_q <= (cfg_wdata != DEVICE_ID);
    end
  end

  // Frame words pass only after a matching identifier
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      frame_data_q <= 32'h00000000;
      frame_valid_q <= 1'b0;
    end
    else
    begin
      frame_valid_q <= 1'b0;
      if (cfg_write && (cfg_addr == cfgopt_pkg::ADDR_FRAME_DATA_INPUT) &&
          id_ok_q)
      begin
        frame_data_q <= cfg_wdata; // [R04]
        frame_valid_q <= 1'b1; // [R04]
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read data selection; unmapped words read zero
  always_comb
  begin
    case (cfg_addr)
      cfgopt_pkg::ADDR_CONFIG_OPTIONS_FIRST: rd_word = first_q;
      cfgopt_pkg::ADDR_CONFIG_OPTIONS_SECOND: rd_word = second_q;
      cfgopt_pkg::ADDR_MULTI_FRAME_WRITE: rd_word = multi_frame_write_q;
      cfgopt_pkg::ADDR_CIPHER_INIT_VECTOR: rd_word = cipher_init_vector_q;
      cfgopt_pkg::ADDR_DEVICE_IDENTIFIER: rd_word = DEVICE_ID; // [R05]
      cfgopt_pkg::ADDR_USER_ACCESS_WORD: rd_word = user_access_word_q;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_rdata_q <= 32'h00000000;
      cfg_rvalid_q <= 1'b0;
    end
    else
    begin
      cfg_rvalid_q <= cfg_read;
      if (cfg_read)
      begin
        cfg_rdata_q <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Startup sequencer
  // ----------------------------------------------------------------
  assign lock_code = first_q[cfgopt_pkg::LOCK_LSB +: 3];
  // Code 7 never equals a running phase below the end
  assign stall = (lock_code != cfgopt_pkg::CODE_KEEP) &&
                 (phase_q == lock_code) && !lock_s2_q; // [R01]

  // One phase per clock, held in the lock wait phase
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= cfgopt_pkg::CFGOPT_IDLE;
      phase_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        cfgopt_pkg::CFGOPT_IDLE:
        begin
          if (wr_cmd && (cfg_wdata[4:0] == cfgopt_pkg::CMD_START))
          begin
            state_q <= cfgopt_pkg::CFGOPT_RUN;
            phase_q <= 3'h0;
          end
        end
        cfgopt_pkg::CFGOPT_RUN:
        begin
          if (!stall) // [R01] [R16]
          begin
            phase_q <= phase_q + 3'h1; // [R16]
            if (phase_q == cfgopt_pkg::PHASE_LAST - 3'h1)
            begin
              state_q <= cfgopt_pkg::CFGOPT_END;
            end
          end
        end
        cfgopt_pkg::CFGOPT_END:
        begin
          phase_q <= cfgopt_pkg::PHASE_LAST;
        end
        default:
        begin
          state_q <= cfgopt_pkg::CFGOPT_IDLE;
        end
      endcase
    end
  end

  // Sequence complete flag
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      startup_done_q <= 1'b0;
    end
    else
    begin
      startup_done_q <= (state_q == cfgopt_pkg::CFGOPT_END);
    end
  end

  // ----------------------------------------------------------------
  // Release units for tristate and write enable
  // ----------------------------------------------------------------
  assign tri_if.code = first_q[cfgopt_pkg::TRISTATE_LSB +: 3]; // [R02]
  assign tri_if.phase = phase_q;
  assign tri_if.running = (state_q != cfgopt_pkg::CFGOPT_IDLE);
  assign tri_if.done = done_seen;
  assign gwe_if.code = first_q[cfgopt_pkg::WRITE_EN_LSB +: 3]; // [R03]
  assign gwe_if.phase = phase_q;
  assign gwe_if.running = (state_q != cfgopt_pkg::CFGOPT_IDLE);
  assign gwe_if.done = done_seen;

  cfgopt_release u_tristate (
    .clock(clock),
    .resetn(resetn),
    .rel(tri_if)
  );

  cfgopt_release u_write_enable (
    .clock(clock),
    .resetn(resetn),
    .rel(gwe_if)
  );

  assign global_tristate_q = tri_if.asserted;
  assign global_write_enable_q = gwe_if.asserted;

  // ----------------------------------------------------------------
  // Persistence and readback CRC controls
  // ----------------------------------------------------------------
  // Persistence drops on command A only when enabled
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_persistence_q <= 1'b1;
    end
    else if (wr_cmd && (cfg_wdata[4:0] == cfgopt_pkg::CMD_COMMAND_A) &&
             second_q[cfgopt_pkg::PIN_PERSISTENCE_REL_BIT])
    begin
      pin_persistence_q <= 1'b0; // [R09]
    end
  end

  // Field outputs and init pin error report
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      readback_crc_response_q <= 2'h0;
      readback_crc_enable_q <= 1'b0;
      init_error_q <= 1'b0;
    end
    else
    begin
      readback_crc_response_q <=
        second_q[cfgopt_pkg::CRC_RESP_LSB +: 2]; // [R10]
      readback_crc_enable_q <= second_q[cfgopt_pkg::CRC_EN_BIT]; // [R12]
      init_error_q <= readback_crc_error &&
                      second_q[cfgopt_pkg::CRC_EN_BIT] &&
                      !second_q[cfgopt_pkg::CRC_NO_PIN_BIT]; // [R11]
    end
  end

  // ----------------------------------------------------------------
  // Flash read timing
  // ----------------------------------------------------------------
  // Latency in cycles and page length in words
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      first_read_latency_q <= 3'h1;
      flash_page_words_q <= 4'h1;
    end
    else
    begin
      first_read_latency_q <=
        {1'b0, second_q[cfgopt_pkg::FIRST_READ_LSB +: 2]} + 3'h1; // [R13]
      case (second_q[cfgopt_pkg::PAGE_LSB +: 2])
        2'h1: flash_page_words_q <= 4'h4; // [R14]
        2'h2: flash_page_words_q <= 4'h8; // [R14]
        default: flash_page_words_q <= 4'h1;
      endcase
    end
  end

endmodule : cfgopt_top

// *** verif/cfgopt_assertions.sv ***
// Port-level checks for the configuration option register block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module cfgopt_assertions #(
  parameter logic [31:0] DEVICE_ID = 32'h00000000
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [4:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_rvalid_q,
  input wire logic compression_active,
  input wire logic readback_crc_error,
  input wire logic frame_valid_q,
  input wire logic [31:0] user_access_word_q,
  input wire logic [31:0] cipher_init_vector_q,
  input wire logic [31:0] multi_frame_write_q,
  input wire logic pin_persistence_q,
  input wire logic [1:0] readback_crc_response_q,
  input wire logic init_error_q,
  input wire logic [2:0] first_read_latency_q,
  input wire logic [3:0] flash_page_words_q
);
  // ------------------------------------------------------------
  // Decoded write strobes
  // ------------------------------------------------------------
  wire wr_sec = cfg_write && cfg_addr == 5'h0E;
  wire wr_mfw = cfg_write && cfg_addr == 5'h0A;
  wire wr_cmd_a = cfg_write && cfg_addr == cfgopt_pkg::ADDR_COMMAND
    && cfg_wdata[4:0] == cfgopt_pkg::CMD_COMMAND_A;

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // Register port relations
  // ------------------------------------------------------------
  chk_read_valid:
    assert property (cfg_read |=> cfg_rvalid_q)
    else $error("read strobe gave no valid pulse");
  chk_id_value:
    assert property (cfg_read && cfg_addr == 5'h0C |=> cfg_rdata_q == DEVICE_ID)
    else $error("identifier read returned another value");
  chk_user_word:
    assert property (cfg_write && cfg_addr == 5'h0D
      |=> user_access_word_q == $past(cfg_wdata))
    else $error("user word not taken from write");
  chk_cipher_vector:
    assert property (cfg_write && cfg_addr == 5'h0B
      |=> cipher_init_vector_q == $past(cfg_wdata))
    else $error("cipher vector not taken from write");
  chk_mfw_gate:
    assert property (wr_mfw && !compression_active
      |=> $stable(multi_frame_write_q))
    else $error("multi-frame write changed without compression");
  chk_frame_cause:
    assert property (frame_valid_q |-> $past(cfg_write) && $past(cfg_addr) == 5'h02)
    else $error("frame pulse without a frame write");
  chk_crc_response:
    assert property (wr_sec |-> ##2
      readback_crc_response_q == $past(cfg_wdata[16:15], 2))
    else $error("crc response field not taken");
  chk_init_cause:
    assert property (init_error_q |-> $past(readback_crc_error))
    else $error("init error without crc error");
  chk_pin_persistence_drop:
    assert property ($fell(pin_persistence_q) |-> $past(wr_cmd_a))
    else $error("persistence dropped without command");
  chk_pin_persistence_keep:
    assert property (!pin_persistence_q |=> !pin_persistence_q)
    else $error("persistence asserted again");
  chk_latency_map:
    assert property (wr_sec |-> ##2
      first_read_latency_q == 3'($past(cfg_wdata[3:2], 2)) + 3'h1)
    else $error("first read latency wrong");
  chk_page_reserved:
    assert property (wr_sec && cfg_wdata[1:0] == 2'h3
      |-> ##2 $stable(flash_page_words_q))
    else $error("reserved page code changed page size");
endmodule : cfgopt_assertions

// *** verif/cfgopt_host_model.sv ***
// Configuration port host: issues one-cycle register reads and writes.
// Assumes the block answers a read with a valid pulse one cycle later.
`timescale 1ns/1ps
module cfgopt_host_model (
  input wire logic clock,
  output logic cfg_write,
  output logic cfg_read,
  output logic [4:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_rvalid_q
);
  // Idle bus at time zero
  initial
  begin
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_addr = 5'h1F;
    cfg_wdata = 32'h0;
  end

  // One write word, changed on the falling edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(negedge clock);
    cfg_write = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clock);
    cfg_write = 1'b0;
    cfg_addr = ~a; // Released lines do not keep the old value
    cfg_wdata = ~d;
  endtask : wr

  // One read word, waits a bounded time for the valid pulse
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic ok);
    int i;
    @(negedge clock);
    cfg_read = 1'b1;
    cfg_addr = a;
    @(negedge clock);
    cfg_read = 1'b0;
    cfg_addr = ~a;
    for (i = 0; i < 3 && cfg_rvalid_q !== 1'b1; i++)
      @(negedge clock);
    ok = cfg_rvalid_q;
    d = cfg_rdata_q;
  endtask : rd
endmodule : cfgopt_host_model

// *** verif/tb.sv ***
// Self-checking bench for the configuration option register block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] DEV_ID = 32'h1234ABCD; // Arbitrary value
  logic clock, resetn, cfg_write, cfg_read, compression_active;
  logic clock_manager_locked, done_pin, readback_crc_error;
  logic cfg_rvalid_q, frame_valid_q, id_error_q, global_tristate_q;
  logic global_write_enable_q, startup_done_q, pin_persistence_q;
  logic readback_crc_enable_q, init_error_q;
  logic [4:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata_q, frame_data_q, user_access_word_q;
  logic [31:0] cipher_init_vector_q, multi_frame_write_q;
  logic [1:0] readback_crc_response_q;
  logic [2:0] first_read_latency_q;
  logic [3:0] flash_page_words_q;
  logic [3:0] page_exp [4] = '{4'h1, 4'h4, 4'h8, 4'h8};
  int error_cnt, compares;

  // Clock of 10 ns
  always #5 clock = ~clock;

  cfgopt_top #(.DEVICE_ID(DEV_ID)) u_cfgopt_top (.*);

  cfgopt_host_model u_cfgopt_host_model (.clock(clock),
    .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("Counts: %0d errors in %0d compares", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    u_cfgopt_host_model.wr(a, d);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [4:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    u_cfgopt_host_model.rd(a, d, ok);
    chk("read valid", 32'h1, {31'h0, ok});
    chk(nm, exp, d);
  endtask : rd_chk

  task automatic do_reset;
    resetn = 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
  endtask : do_reset

  // Counts clock cycles until a startup output reaches a level
  task automatic wait_lvl(input int sel, input logic lvl, output int n);
    logic v;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
      v = sel == 0 ? global_tristate_q : global_write_enable_q;
      v = sel == 2 ? startup_done_q : v;
    end
    while (v !== lvl && n < 40);
    if (v !== lvl)
    begin
      error_cnt++;
      $display("unexpected timeout: expected %b, seen %b", lvl, v);
      stop_test();
    end
  endtask : wait_lvl

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    int n, m, n1;
    logic [1:0] k2;
    logic [31:0] d;
    clock = 1'b0;
    resetn = 1'b0;
    compression_active = 1'b0;
    clock_manager_locked = 1'b0;
    done_pin = 1'b0;
    readback_crc_error = 1'b0;
    do_reset();
    chk("reset outs", 11'h711, {global_tristate_q, global_write_enable_q,
      pin_persistence_q, startup_done_q, first_read_latency_q,
      flash_page_words_q});
    rd_chk("first opts", 5'h09, cfgopt_pkg::FIRST_RESET);
    rd_chk("second opts", 5'h0E, 32'h0);
    wr(5'h02, 32'h11111111);
    chk("frame before id", 32'h0, frame_valid_q);
    wr(5'h0C, ~DEV_ID);
    wr(5'h02, 32'h22222222);
    chk("frame bad id", 2'h2, {id_error_q, frame_valid_q});
    wr(5'h0C, DEV_ID);
    wr(5'h02, 32'h3C3C5A5A);
    chk("frame good id", 2'h1, {id_error_q, frame_valid_q});
    chk("frame data", 32'h3C3C5A5A, frame_data_q);
    rd_chk("identifier", 5'h0C, DEV_ID);
    rd_chk("unmapped", 5'h1F, 32'h0);
    wr(5'h0D, 32'hA5A50F0F);
    chk("user word", 32'hA5A50F0F, user_access_word_q);
    rd_chk("user read", 5'h0D, 32'hA5A50F0F);
    wr(5'h0B, 32'h0123CDEF);
    chk("cipher", 32'h0123CDEF, cipher_init_vector_q);
    wr(5'h0A, 32'h00007777);
    chk("mfw gated", 32'h0, multi_frame_write_q);
    compression_active = 1'b1;
    wr(5'h0A, 32'h00007777);
    chk("mfw open", 32'h00007777, multi_frame_write_q);
    // Every code of the second options fields below bit 17
    for (int k = 0; k < 4; k++)
    begin
      k2 = 2'(k);
      d = {15'h0, k2, 5'h0, k2, 4'h0, k2, k2};
      wr(5'h0E, d);
      @(negedge clock);
      chk("crc resp", k2, readback_crc_response_q);
      chk("crc en", k2[0], readback_crc_enable_q);
      chk("latency", 3'(k2) + 3'h1, first_read_latency_q);
      chk("page", page_exp[k], flash_page_words_q);
      rd_chk("second rd", 5'h0E, {d[31:2], k == 3 ? 2'h2 : k2});
    end
    // Persistence release by command A
    wr(5'h0E, 32'h0);
    wr(5'h04, 32'(cfgopt_pkg::CMD_COMMAND_A));
    chk("pin_persistence kept", 1'b1, pin_persistence_q);
    wr(5'h0E, 32'h00020000);
    wr(5'h04, 32'(cfgopt_pkg::CMD_COMMAND_A));
    chk("pin_persistence drop", 1'b0, pin_persistence_q);
    // Readback crc error on the init pin
    readback_crc_error = 1'b1;
    repeat (2) @(negedge clock);
    chk("init off", 1'b0, init_error_q);
    wr(5'h0E, 32'h00000100);
    @(negedge clock);
    chk("init shown", 1'b1, init_error_q);
    wr(5'h0E, 32'h00000300);
    @(negedge clock);
    chk("init muted", 1'b0, init_error_q);
    readback_crc_error = 1'b0;
    // Startup without lock wait: tristate phase 1, write enable kept
    wr(5'h09, 32'h020001C7);
    rd_chk("first rd", 5'h09, 32'h020001C7
      | (cfgopt_pkg::FIRST_RESET & ~cfgopt_pkg::FIRST_MASK));
    wr(5'h04, 32'(cfgopt_pkg::CMD_START));
    wait_lvl(0, 1'b0, n);
    chk("tristate cycles", 32'd2, n);
    wait_lvl(2, 1'b1, m);
    chk("done cycles", 32'd8, n + m);
    chk("gwe kept", 1'b1, global_write_enable_q);
    // Stall at phase 1, write enable at phase 4, tristate follows done
    do_reset();
    wr(5'h09, 32'h02000073);
    wr(5'h04, 32'(cfgopt_pkg::CMD_START));
    repeat (20) @(negedge clock);
    chk("stalled", 2'h2, {global_write_enable_q, startup_done_q});
    clock_manager_locked = 1'b1;
    wait_lvl(1, 1'b0, n);
    chk("lock resume", 1'b1, n >= 3 && n <= 10);
    wait_lvl(2, 1'b1, n);
    chk("tristate low done", 1'b1, global_tristate_q);
    done_pin = 1'b1;
    wait_lvl(0, 1'b0, n1);
    done_pin = 1'b0;
    wait_lvl(0, 1'b1, n);
    chk("tristate tracks", 32'(n1), n);
    // Done response one clock sooner without the pipeline stage
    do_reset();
    wr(5'h09, 32'h000001F0);
    wr(5'h04, 32'(cfgopt_pkg::CMD_START));
    wait_lvl(2, 1'b1, n);
    done_pin = 1'b1;
    wait_lvl(0, 1'b0, n);
    chk("done pipe delay", 32'd1, n1 - n);
    stop_test();
  end
endmodule : tb

bind cfgopt_top cfgopt_assertions #(.DEVICE_ID(DEVICE_ID))
  u_cfgopt_assertions (.*);
